//--- logic/cmd_decoder_pkg.sv
// Constants, field layouts and carrier types for the sub-bit command decoder.
// Assumes a 10 MHz system clock and a single AHB-Lite master reaching the registers.
// How it works
// - Sample the data tone once per reference cycle, at one delayed instant.
// - Data tone high at sampling gives a one sub-bit pulse of 200 us.
// - Data tone low at sampling gives a zero sub-bit; never both at once.
// - Without reference amplitude no sampling instant occurs, so noise yields no sub-bits.
// - Sub-bit leading edge shifts the 5-bit register; trailing edge loads the value.
// - Three fixed patterns recognise address, one and zero bits.
// - An all-ones sub-bit stream matches none of the patterns.
// - A message is 3 address bits followed by 32 data bits.
// - With timer idle an address match anywhere restarts counting and starts the timer.
// - Missing-bit timer: two alternating 5.4 ms one-shots; running enables counted compares.
// - While running, sub-bits are counted and compared only at the fifth.
// - Second address bit clears data register, bit counter and output flip-flop.
// - With three address bits seen, data bits are admitted.
// - Each data bit retriggers the timer, shifts into data and counts.
// - The 32nd bit opens a 1 ms address-check window; a match sets the output.
// - A correct address fires two redundant 60 ms telemetry pulses.
// - A set output clears the address counter and presents 18 data bits.
// - Acknowledge clears data and output and fires two 60 ms telemetry pulses.
// - Without acknowledge, a set output holds the address counter at zero, so no later message is decoded.
// - Each bit is exactly five sub-bits.
// - The check covers the vehicle address and a 14-bit decoder address.
// - Each bit must arrive within its 5 ms period.
// - A missing bit or wrong address stops decoding of the current message.

package cmd_decoder_pkg;

  localparam int CLK_PERIOD_NS   = 100;
  localparam int SUBBIT_PULSE_NS = 200_000;
  localparam int MISSING_BIT_NS  = 5_400_000;
  localparam int CHECK_WINDOW_NS = 1_000_000;
  localparam int TELEMETRY_NS    = 60_000_000;

  // Pulse widths are least times, so they round up.
  localparam int SUBBIT_CYC  = (SUBBIT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MISSING_CYC = (MISSING_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WINDOW_CYC  = (CHECK_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TELEM_CYC   = (TELEMETRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int SUBBITS_PER_BIT = 5;
  localparam int VEHICLE_BITS    = 3;
  localparam int WORD_BITS       = 32;
  localparam int DEC_ADDR_W      = 14;
  localparam int OUT_W           = 18;

  localparam logic [4:0] PAT_ONE  = 5'h1a;
  localparam logic [4:0] PAT_ZERO = 5'h05;
  localparam logic [4:0] PAT_ADDR = 5'h18;

  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_DEC_ADDR = 8'h04;
  localparam logic [7:0] OFF_SAMPLE   = 8'h08;
  localparam logic [7:0] OFF_STATUS   = 8'h0c;
  localparam logic [7:0] OFF_DATA     = 8'h10;

  localparam int CTRL_EN_BIT     = 0;
  localparam int STAT_MISS_BIT   = 10;
  localparam int STAT_FAIL_BIT   = 11;
  localparam logic        CTRL_RST     = 1'h1;
  localparam logic [13:0] DEC_ADDR_RST = 14'h0000;
  localparam logic [15:0] SAMPLE_RST   = 16'h09c4;

  typedef struct packed {
    logic       addr_fail;
    logic       missing_bit;
    logic       out_valid;
    logic       timer_run;
    logic [1:0] addr_count;
    logic [5:0] bit_count;
  } status_t;

  typedef struct packed {
    logic       hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic       hwrite;
    logic [2:0] hsize;
    logic       hready;
  } ahb_req_t;

endpackage

//--- logic/subbit_command_decoder.sv
// Sub-bit detector and main decoder for an uplinked command message.
// Assumes squared reference and data tones and a threshold level from the receiver,
// an acknowledge pulse from the flight data adapter, and an AHB-Lite master.
`timescale 1ns/1ps
`default_nettype none

module subbit_command_decoder
  import cmd_decoder_pkg::*;
#(
  parameter int MISS_CYC  = cmd_decoder_pkg::MISSING_CYC,
  parameter int WIN_CYC   = cmd_decoder_pkg::WINDOW_CYC,
  parameter int TELEM_LEN = cmd_decoder_pkg::TELEM_CYC
) (
  input  wire logic                              sys_clk,
  input  wire logic                              reset,
  input  wire logic                              ref_tone,
  input  wire logic                              data_tone,
  input  wire logic                              threshold_gate,
  input  wire logic                              ack_in,
  input  wire cmd_decoder_pkg::ahb_req_t         ahb_req,
  input  wire logic [31:0]                       hwdata,
  output logic                                   hreadyout,
  output logic                                   hresp,
  output logic [31:0]                            hrdata,
  output logic [cmd_decoder_pkg::OUT_W-1:0]      data_out,
  output logic                                   data_valid,
  output logic                                   subbit_one,
  output logic                                   subbit_zero,
  output logic [1:0]                             addr_ok_tm,
  output logic [1:0]                             ack_tm
);
  import cmd_decoder_pkg::*;

  localparam int MW = $clog2(MISS_CYC + 1);
  localparam int WW = $clog2(WIN_CYC + 1);
  localparam int TW = $clog2(TELEM_LEN + 1);
  localparam int SW = $clog2(SUBBIT_CYC + 1);
  localparam logic [MW-1:0] MISS_LOAD  = MW'(MISS_CYC);
  localparam logic [WW-1:0] WIN_LOAD   = WW'(WIN_CYC);
  localparam logic [TW-1:0] TELEM_LOAD = TW'(TELEM_LEN);
  localparam logic [SW-1:0] PULSE_LOAD = SW'(SUBBIT_CYC);
  localparam logic [2:0]    LAST_SUB   = 3'(SUBBITS_PER_BIT - 1);
  localparam logic [5:0]    LAST_BIT   = 6'(WORD_BITS - 1);
  localparam logic [5:0]    FULL_WORD  = 6'(WORD_BITS);
  localparam logic [1:0]    ALL_VEH    = 2'(VEHICLE_BITS);

  // Pin index order: 0 reference, 1 data tone, 2 threshold, 3 acknowledge.
  logic [3:0] pins;
  logic [3:0] s1_q, s2_q, s3_q, flt_q, prev_q;

  assign pins = {ack_in, threshold_gate, data_tone, ref_tone};

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s1_q   <= 4'h0;
      s2_q   <= 4'h0;
      s3_q   <= 4'h0;
      flt_q  <= 4'h0;
      prev_q <= 4'h0;
    end else begin
      s1_q   <= pins;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      prev_q <= flt_q;
      for (int i = 0; i < 4; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          flt_q[i] <= s3_q[i];
        end
      end
    end
  end

  logic ref_rise, ack_rise, gate_ok;
  assign ref_rise = flt_q[0] & ~prev_q[0];
  assign ack_rise = flt_q[3] & ~prev_q[3];
  assign gate_ok  = flt_q[2];

  // Registers.
  logic        enable_q;
  logic [13:0] dec_addr_q;
  logic [15:0] sample_dly_q;
  logic        miss_flag_q, fail_flag_q;

  // Sampling one-shot: the delay places the instant mid-way into the data tone's
  // positive half; a zero delay would never fire, so it is forced to one.
  logic [15:0] samp_cnt_q;
  logic        sample_now;
  assign sample_now = (samp_cnt_q == 16'h0001);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      samp_cnt_q <= 16'h0000;
    end else if (!gate_ok || !enable_q) begin
      samp_cnt_q <= 16'h0000;
    end else if (ref_rise) begin
      samp_cnt_q <= (sample_dly_q == 16'h0000) ? 16'h0001 : sample_dly_q;
    end else if (samp_cnt_q != 16'h0000) begin
      samp_cnt_q <= samp_cnt_q - 16'h0001;
    end
  end

  // Sub-bit pulse stretcher.
  logic [SW-1:0] pulse_cnt_q;
  logic          subbit_one_q, subbit_zero_q;
  logic          sb_lead, sb_trail;
  assign sb_lead  = sample_now && (pulse_cnt_q == '0);
  assign sb_trail = (pulse_cnt_q == SW'(1));

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pulse_cnt_q   <= '0;
      subbit_one_q  <= 1'b0;
      subbit_zero_q <= 1'b0;
    end else if (sb_lead) begin
      pulse_cnt_q   <= PULSE_LOAD;
      subbit_one_q  <= flt_q[1];
      subbit_zero_q <= ~flt_q[1];
    end else if (sb_trail) begin
      pulse_cnt_q   <= '0;
      subbit_one_q  <= 1'b0;
      subbit_zero_q <= 1'b0;
    end else if (pulse_cnt_q != '0) begin
      pulse_cnt_q <= pulse_cnt_q - SW'(1);
    end
  end

  // Sub-bit shift register: the lead makes room, the trail writes the value.
  logic [4:0] sr5_q;
  logic [4:0] new_pat;
  assign new_pat = {sr5_q[4:1], subbit_one_q};

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sr5_q <= 5'h1f;
    end else if (sb_lead) begin
      sr5_q <= {sr5_q[3:0], 1'b0};
    end else if (sb_trail) begin
      sr5_q <= new_pat;
    end
  end

  // Comparators see the pattern as it is written on the trailing edge.
  logic x_hit, one_hit, zero_hit;
  assign x_hit    = (new_pat == PAT_ADDR);
  assign one_hit  = (new_pat == PAT_ONE);
  assign zero_hit = (new_pat == PAT_ZERO);

  // Missing-bit timer.
  logic [MW-1:0] mb_a_q, mb_b_q;
  logic          mb_sel_q, run_prev_q;
  logic          timer_run, timer_exp;
  assign timer_run = (mb_a_q != '0) || (mb_b_q != '0);
  assign timer_exp = run_prev_q && !timer_run;

  logic [2:0] cnt5_q;
  logic [1:0] cnt3_q;
  logic [5:0] cnt32_q;
  logic       out_ff_q;
  logic [31:0] data_q;
  logic        cmp_now, x_idle, x_cnt, bit_ok, retrig, clear_msg;

  assign cmp_now   = sb_trail && timer_run && (cnt5_q == LAST_SUB);
  assign x_idle    = sb_trail && !timer_run && x_hit && enable_q;
  assign x_cnt     = cmp_now && x_hit && (cnt3_q == 2'h1 || cnt3_q == 2'h2);
  assign bit_ok    = cmp_now && (one_hit || zero_hit) && (cnt3_q == ALL_VEH)
                     && (cnt32_q < FULL_WORD);
  assign retrig    = x_idle || x_cnt || bit_ok;
  assign clear_msg = x_cnt && (cnt3_q == 2'h1);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mb_a_q     <= '0;
      mb_b_q     <= '0;
      mb_sel_q   <= 1'b0;
      run_prev_q <= 1'b0;
    end else begin
      run_prev_q <= timer_run;
      // Alternating one-shots overlap, so a retrigger never sees a gap.
      if (retrig && !mb_sel_q) begin
        mb_a_q <= MISS_LOAD;
      end else if (mb_a_q != '0) begin
        mb_a_q <= mb_a_q - MW'(1);
      end
      if (retrig && mb_sel_q) begin
        mb_b_q <= MISS_LOAD;
      end else if (mb_b_q != '0) begin
        mb_b_q <= mb_b_q - MW'(1);
      end
      if (retrig) begin
        mb_sel_q <= ~mb_sel_q;
      end
    end
  end

  // Sub-bit counter runs only while the timer runs.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt5_q <= 3'h0;
    end else if (x_idle || !timer_run) begin
      cnt5_q <= 3'h0;
    end else if (sb_trail) begin
      cnt5_q <= (cnt5_q == LAST_SUB) ? 3'h0 : cnt5_q + 3'h1;
    end
  end

  // Address check window.
  logic [WW-1:0] win_cnt_q;
  logic          win_open, addr_match, out_set, win_fail;
  assign win_open   = (win_cnt_q != '0);
  assign addr_match = (data_q[WORD_BITS-1 -: DEC_ADDR_W] == dec_addr_q);
  assign out_set    = win_open && addr_match && !out_ff_q && (cnt3_q == ALL_VEH);
  assign win_fail   = (win_cnt_q == WW'(1)) && !out_set;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      win_cnt_q <= '0;
    end else if (bit_ok && cnt32_q == LAST_BIT) begin
      win_cnt_q <= WIN_LOAD;
    end else if (out_set || clear_msg) begin
      win_cnt_q <= '0;
    end else if (win_open) begin
      win_cnt_q <= win_cnt_q - WW'(1);
    end
  end

  // Vehicle-address counter. Any failure drops it to zero, which closes the data
  // path until a fresh address bit arrives with the timer idle.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt3_q <= 2'h0;
    end else if (out_ff_q || timer_exp || win_fail) begin
      cnt3_q <= 2'h0;
    end else if (x_idle) begin
      cnt3_q <= 2'h1;
    end else if (x_cnt) begin
      cnt3_q <= cnt3_q + 2'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt32_q <= 6'h00;
    end else if (clear_msg) begin
      cnt32_q <= 6'h00;
    end else if (bit_ok) begin
      cnt32_q <= cnt32_q + 6'h01;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      data_q <= 32'h0000_0000;
    end else if (clear_msg || ack_rise) begin
      data_q <= 32'h0000_0000;
    end else if (bit_ok) begin
      data_q <= {data_q[30:0], one_hit};
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      out_ff_q <= 1'b0;
    end else if (clear_msg || ack_rise) begin
      out_ff_q <= 1'b0;
    end else if (out_set) begin
      out_ff_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      data_out   <= '0;
      data_valid <= 1'b0;
    end else begin
      data_out   <= out_ff_q ? data_q[OUT_W-1:0] : '0;
      data_valid <= out_ff_q;
    end
  end

  // Telemetry one-shots: two redundant copies for address and for acknowledge.
  logic [TW-1:0] tm_cnt_q [4];
  logic [3:0]    tm_fire;
  logic [3:0]    tm_out_q;
  assign tm_fire = {ack_rise, ack_rise, out_set, out_set};

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) begin
        tm_cnt_q[i] <= '0;
      end
      tm_out_q <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (tm_fire[i]) begin
          tm_cnt_q[i] <= TELEM_LOAD;
          tm_out_q[i] <= 1'b1;
        end else if (tm_cnt_q[i] == TW'(1)) begin
          tm_cnt_q[i] <= '0;
          tm_out_q[i] <= 1'b0;
        end else if (tm_cnt_q[i] != '0) begin
          tm_cnt_q[i] <= tm_cnt_q[i] - TW'(1);
        end
      end
    end
  end

  assign addr_ok_tm  = tm_out_q[1:0];
  assign ack_tm      = tm_out_q[3:2];
  assign subbit_one  = subbit_one_q;
  assign subbit_zero = subbit_zero_q;

  // AHB-Lite slave. Writes finish with no wait state; reads take one wait state so
  // that a write in the preceding data phase is already visible.
  logic       wr_pend_q, rd_pend_q;
  logic [7:0] dp_addr_q;
  logic       addr_phase;
  status_t    status;
  assign addr_phase = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
  assign status = '{addr_fail: fail_flag_q, missing_bit: miss_flag_q, out_valid: out_ff_q,
                    timer_run: timer_run, addr_count: cnt3_q, bit_count: cnt32_q};

  function automatic logic [31:0] read_mux(input logic [7:0] a);
    case (a)
      OFF_CTRL:     read_mux = {31'h0, enable_q};
      OFF_DEC_ADDR: read_mux = {18'h0, dec_addr_q};
      OFF_SAMPLE:   read_mux = {16'h0, sample_dly_q};
      OFF_STATUS:   read_mux = {20'h0, status};
      OFF_DATA:     read_mux = data_q;
      default:      read_mux = 32'h0000_0000;
    endcase
  endfunction

  logic wr_en;
  assign wr_en = wr_pend_q;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      dp_addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
    end else begin
      wr_pend_q <= addr_phase && ahb_req.hwrite;
      rd_pend_q <= addr_phase && !ahb_req.hwrite;
      if (addr_phase) begin
        dp_addr_q <= {ahb_req.haddr[7:2], 2'b00};
      end
      hreadyout <= !(addr_phase && !ahb_req.hwrite);
      if (rd_pend_q) begin
        hrdata <= read_mux(dp_addr_q);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      enable_q     <= CTRL_RST;
      dec_addr_q   <= DEC_ADDR_RST;
      sample_dly_q <= SAMPLE_RST;
    end else if (wr_en) begin
      case (dp_addr_q)
        OFF_CTRL:     enable_q     <= hwdata[CTRL_EN_BIT];
        OFF_DEC_ADDR: dec_addr_q   <= hwdata[DEC_ADDR_W-1:0];
        OFF_SAMPLE:   sample_dly_q <= hwdata[15:0];
        default:      ;
      endcase
    end
  end

  // Sticky fault flags: a new fault in the clearing cycle survives the clear.
  logic clr_stat;
  assign clr_stat = wr_en && (dp_addr_q == OFF_STATUS);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      miss_flag_q <= 1'b0;
      fail_flag_q <= 1'b0;
    end else begin
      if (timer_exp && cnt3_q != 2'h0) begin
        miss_flag_q <= 1'b1;
      end else if (clr_stat && hwdata[STAT_MISS_BIT]) begin
        miss_flag_q <= 1'b0;
      end
      if (win_fail) begin
        fail_flag_q <= 1'b1;
      end else if (clr_stat && hwdata[STAT_FAIL_BIT]) begin
        fail_flag_q <= 1'b0;
      end
    end
  end

endmodule // subbit_command_decoder

`default_nettype wire

//--- dv/cmd_decoder_asserts.sv
// Port-level assertions for the sub-bit command decoder.
// Bound to every decoder instance; sees the decoder's ports except data_tone, hwdata and hrdata, its three timing parameters and no internal signal.
`timescale 1ns/1ps
`default_nettype none

module cmd_decoder_asserts
  import cmd_decoder_pkg::*;
#(
  parameter int MISS_CYC  = 54000,
  parameter int WIN_CYC   = 10000,
  parameter int TELEM_LEN = 600000,
  parameter int GATE_SPAN = 8
) (
  input wire logic                          sys_clk,
  input wire logic                          reset,
  input wire logic                          ref_tone,
  input wire logic                          threshold_gate,
  input wire logic                          ack_in,
  input wire cmd_decoder_pkg::ahb_req_t     ahb_req,
  input wire logic                          hreadyout,
  input wire logic                          hresp,
  input wire logic [cmd_decoder_pkg::OUT_W-1:0] data_out,
  input wire logic                          data_valid,
  input wire logic                          subbit_one,
  input wire logic                          subbit_zero,
  input wire logic [1:0]                    addr_ok_tm,
  input wire logic [1:0]                    ack_tm
);
  logic [11:0] sb_len_q;
  logic [19:0] tm_len_q;
  logic [16:0] low_q;
  logic        ref_seen_q;
  wire  logic  sb_any = subbit_one | subbit_zero;
  wire  logic  taken  = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Run lengths are measured here so the widths can be checked exactly at the falling edge.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sb_len_q <= '0;
      tm_len_q <= '0;
    end else begin
      sb_len_q <= sb_any ? sb_len_q + 12'h001 : 12'h000;
      tm_len_q <= ack_tm[0] ? tm_len_q + 20'h00001 : 20'h00000;
    end
  end

  // A pending sample may outlive a falling gate, so only a long quiet gate is held against it.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) low_q <= '0;
    else if (threshold_gate) low_q <= '0;
    else if (low_q != '1) low_q <= low_q + 17'h00001;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) ref_seen_q <= 1'b1;
    else if ($rose(sb_any)) ref_seen_q <= 1'b0;
    else if (ref_tone) ref_seen_q <= 1'b1;
  end

  property p_excl; !(subbit_one && subbit_zero); endproperty
  a_excl: assert property (p_excl)
    else $error("one and zero sub-bits high together");
  property p_width; $fell(sb_any) |-> sb_len_q == 12'(SUBBIT_CYC); endproperty
  a_width: assert property (p_width)
    else $error("sub-bit pulse width wrong");
  property p_gate; $rose(sb_any) |-> low_q < 17'(GATE_SPAN); endproperty
  a_gate: assert property (p_gate)
    else $error("sub-bit while threshold gate low");
  property p_ref; $rose(sb_any) |-> ref_seen_q; endproperty
  a_ref: assert property (p_ref)
    else $error("two sub-bits from one reference cycle");
  property p_ack_tm; $rose(ack_in) |-> ##[2:10] (ack_tm == 2'b11); endproperty
  a_ack_tm: assert property (p_ack_tm)
    else $error("acknowledge telemetry did not fire");
  property p_ack_len; $fell(ack_tm[0]) |-> tm_len_q == 20'(TELEM_LEN); endproperty
  a_ack_len: assert property (p_ack_len)
    else $error("acknowledge telemetry length wrong");
  property p_ack_clr; $rose(ack_in) |-> ##[2:10] (!data_valid && data_out == '0); endproperty
  a_ack_clr: assert property (p_ack_clr)
    else $error("acknowledge left outputs enabled");
  property p_pair;
    (ack_tm[0] == ack_tm[1]) && (addr_ok_tm[0] == addr_ok_tm[1]);
  endproperty
  a_pair: assert property (p_pair)
    else $error("redundant telemetry pulses differ");
  property p_out; data_out != '0 |-> ##[0:2] data_valid; endproperty
  a_out: assert property (p_out)
    else $error("data outputs driven while disabled");
  property p_okay; !hresp; endproperty
  a_okay: assert property (p_okay)
    else $error("bus response not okay");
  property p_rd; taken && !ahb_req.hwrite |=> !hreadyout ##1 hreadyout; endproperty
  a_rd: assert property (p_rd)
    else $error("read wait state wrong");
  property p_wr; taken && ahb_req.hwrite |=> hreadyout; endproperty
  a_wr: assert property (p_wr)
    else $error("write stalled");
endmodule // cmd_decoder_asserts

bind subbit_command_decoder cmd_decoder_asserts #(
  .MISS_CYC(MISS_CYC), .WIN_CYC(WIN_CYC), .TELEM_LEN(TELEM_LEN)
) chk_inst (
  .sys_clk(sys_clk), .reset(reset), .ref_tone(ref_tone), .threshold_gate(threshold_gate),
  .ack_in(ack_in), .ahb_req(ahb_req), .hreadyout(hreadyout), .hresp(hresp),
  .data_out(data_out), .data_valid(data_valid), .subbit_one(subbit_one),
  .subbit_zero(subbit_zero), .addr_ok_tm(addr_ok_tm), .ack_tm(ack_tm)
);

`default_nettype wire

//--- dv/cmd_link_model.sv
// Behavioural receiver baseband: squared reference and data tones plus threshold level.
// Value and carrier are latched once per period; take marks that latch.
`timescale 1ns/1ps
`default_nettype none

module cmd_link_model #(
  parameter int PERIOD = 2200,
  parameter int REF_AT = 100
) (
  input  wire logic sys_clk,
  input  wire logic sb_val,
  input  wire logic carrier,
  output logic      ref_tone,
  output logic      data_tone,
  output logic      threshold_gate,
  output logic      take
);
  int   ph;
  int   rel;
  logic v_q;

  // The gate starts low so no sub-bit is made before the first latched value.
  initial begin
    ph = 0;
    v_q = 1'b1;
    ref_tone = 1'b0;
    data_tone = 1'b0;
    threshold_gate = 1'b0;
    take = 1'b0;
  end

  // Without carrier the data line toggles every cycle, as noise would.
  always @(posedge sys_clk) begin
    ph <= (ph == PERIOD - 1) ? 0 : ph + 1;
    take <= (ph == PERIOD - 1);
    if (ph == PERIOD - 1) begin
      v_q <= sb_val;
      threshold_gate <= carrier;
    end
    rel = (ph + 1 + PERIOD - REF_AT) % PERIOD;
    ref_tone <= rel < PERIOD / 2;
    if (threshold_gate) data_tone <= (((rel % (PERIOD / 2)) < PERIOD / 4) == v_q);
    else data_tone <= ~data_tone;
  end
endmodule // cmd_link_model

`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the sub-bit command decoder.
// Drives the link model, the acknowledge pin and an AHB-Lite master.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import cmd_decoder_pkg::*;
  localparam int          P   = 2200;
  localparam int          TL  = 50;
  localparam logic [31:0] SMP = 32'h0000_055f;

  logic             sys_clk, reset, ack_in, sb_val, carrier;
  logic             ref_tone, data_tone, threshold_gate, take;
  logic             hreadyout, hresp, data_valid, subbit_one, subbit_zero, sb_prev;
  logic [1:0]       addr_ok_tm, ack_tm;
  logic [OUT_W-1:0] data_out;
  logic [31:0]      hwdata, hrdata, rd;
  ahb_req_t         req, bus;
  int               fail_count = 0;
  int               checked = 0;
  logic             exp_q[$];

  always_comb begin
    bus = req;
    bus.hready = hreadyout;
  end

  subbit_command_decoder #(.MISS_CYC(11500), .WIN_CYC(100), .TELEM_LEN(TL))
    subbit_command_decoder_inst (
    .sys_clk(sys_clk), .reset(reset), .ref_tone(ref_tone), .data_tone(data_tone),
    .threshold_gate(threshold_gate), .ack_in(ack_in), .ahb_req(bus), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .data_out(data_out),
    .data_valid(data_valid), .subbit_one(subbit_one), .subbit_zero(subbit_zero),
    .addr_ok_tm(addr_ok_tm), .ack_tm(ack_tm));

  cmd_link_model #(.PERIOD(P)) cmd_link_model_inst (
    .sys_clk(sys_clk), .sb_val(sb_val), .carrier(carrier), .ref_tone(ref_tone),
    .data_tone(data_tone), .threshold_gate(threshold_gate), .take(take));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic complete_run;
    if (fail_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic give_up;
    fail_count++;
    complete_run();
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_sb(input logic [1:0] got, input logic [1:0] exp);
    cmp({30'h0, got}, {30'h0, exp});
  endtask

  function automatic logic [31:0] stat(input logic [1:0] ac, input logic [5:0] bc);
    status_t s;
    s = '0;
    s.addr_count = ac;
    s.bit_count = bc;
    s.timer_run = 1'b1;
    return {20'h0, s};
  endfunction

  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) give_up();
      @(posedge sys_clk);
    end
  endtask

  task automatic bus_op(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    req <= '{hsel: 1'b1, haddr: {24'h0, a}, htrans: 2'b10, hwrite: wr, hsize: 3'h2,
             hready: 1'b1};
    wait_ready();
    req.hsel <= 1'b0;
    req.htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_op(1'b1, a, d);
  endtask

  task automatic rd_cmp(input logic [7:0] a, input logic [31:0] e);
    bus_op(1'b0, a, 32'h0);
    cmp(rd, e);
  endtask

  // Returns just after the model latched the value, which is then expected on a pulse if carrier is set.
  task automatic send(input logic v);
    int n;
    n = 0;
    sb_val <= v;
    @(posedge sys_clk);
    while (take !== 1'b1) begin
      n++;
      if (n > P + 10) give_up();
      @(posedge sys_clk);
    end
    if (carrier) exp_q.push_back(v);
  endtask

  task automatic send_pat(input logic [4:0] p);
    for (int i = 4; i >= 0; i--) send(p[i]);
  endtask

  always @(posedge sys_clk) begin
    sb_prev <= subbit_one | subbit_zero;
    if ((subbit_one | subbit_zero) && !sb_prev) begin
      if (exp_q.size() == 0) cmp_sb({subbit_one, subbit_zero}, 2'b00);
      else cmp_sb({subbit_one, subbit_zero}, exp_q.pop_front() ? 2'b10 : 2'b01);
    end
  end

  initial begin
    #(105_000 * 100);
    give_up();
  end

  initial begin
    logic [31:0] w;
    logic [1:0]  b;
    int          n;
    reset = 1'b1;
    ack_in = 1'b0;
    sb_val = 1'b1;
    carrier = 1'b1;
    hwdata = '0;
    req = '0;
    void'($urandom(21));
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    rd_cmp(OFF_SAMPLE, {16'h0, SAMPLE_RST});
    wr(OFF_SAMPLE, SMP);
    rd_cmp(OFF_CTRL, {31'h0, CTRL_RST});
    rd_cmp(OFF_DEC_ADDR, {18'h0, DEC_ADDR_RST});
    rd_cmp(OFF_STATUS, 32'h0);
    w = $urandom & 32'h3fff;
    wr(OFF_DEC_ADDR, w);
    wr(8'h20, 32'hffff_ffff);
    rd_cmp(OFF_DEC_ADDR, w);
    rd_cmp(8'h20, 32'h0);
    for (int i = 0; i < 3; i++) send(1'b1);
    rd_cmp(OFF_STATUS, 32'h0);
    for (int i = 0; i < 4; i++) send(1'($urandom));
    // A random stream may start a message, so the decoder is reset in mid-run.
    reset <= 1'b1;
    @(posedge sys_clk);
    reset <= 1'b0;
    wr(OFF_SAMPLE, SMP);
    carrier <= 1'b0;
    for (int i = 0; i < 3; i++) send(1'b1);
    carrier <= 1'b1;
    send(1'b1);
    send(1'b1);
    b[0] = 1'($urandom);
    b[1] = ~b[0];
    repeat (3) send_pat(PAT_ADDR);
    send_pat(b[1] ? PAT_ONE : PAT_ZERO);
    send_pat(b[0] ? PAT_ONE : PAT_ZERO);
    send(1'b1);
    send(1'b1);
    rd_cmp(OFF_STATUS, stat(2'h3, 6'h02));
    rd_cmp(OFF_DATA, {30'h0, b});
    n = 0;
    do begin
      send(1'b1);
      bus_op(1'b0, OFF_STATUS, 32'h0);
      n++;
    end while (rd[STAT_MISS_BIT] !== 1'b1 && n < 8);
    cmp(32'(n), 32'h5);
    cmp({31'h0, rd[STAT_MISS_BIT]}, 32'h1);
    wr(OFF_STATUS, 32'h0000_0400);
    bus_op(1'b0, OFF_STATUS, 32'h0);
    cmp({31'h0, rd[STAT_MISS_BIT]}, 32'h0);
    ack_in <= 1'b1;
    n = 0;
    for (int i = 0; i < TL + 40; i++) begin
      @(posedge sys_clk);
      if (i == 20) ack_in <= 1'b0;
      if (ack_tm === 2'b11) n++;
    end
    cmp(32'(n), 32'(TL));
    rd_cmp(OFF_DATA, 32'h0);
    complete_run();
  end
endmodule // tb

`default_nettype wire
